// File: hw/gpio_port_pkg.sv
// Constants, register map and types for the parallel I/O port block.
// Assumes a 16-bit port behind a 32-bit classic Wishbone slave.
package gpio_port_pkg;

    // ****************************************************************
    // Widths and pin masks.
    // ****************************************************************
    localparam int          PORT_W      = 16;
    localparam int          DATA_W      = 32;
    localparam int          ADR_W       = 8;
    localparam int          SEL_W       = 4;
    // Pins present on this port; absent pins read as zero everywhere.
    localparam logic [15:0] IMPL_MASK   = 16'hBFFF;
    // Pins that share a function with an analog input.
    localparam logic [15:0] ANALOG_MASK = 16'h00FF;
    // Pin that carries the comparator reference output.
    localparam logic [15:0] CREF_MASK   = 16'h0400;

    // ****************************************************************
    // Register map: byte address = index * 16 + companion * 4.
    // ****************************************************************
    localparam logic [3:0]  IDX_DIR     = 4'h0;
    localparam logic [3:0]  IDX_PORT    = 4'h1;
    localparam logic [3:0]  IDX_LAT     = 4'h2;
    localparam logic [3:0]  IDX_ODC     = 4'h3;
    localparam logic [3:0]  IDX_ANCFG   = 4'h4;
    localparam logic [3:0]  IDX_CNEN    = 4'h5;
    localparam logic [3:0]  IDX_CNPU    = 4'h6;

    // ****************************************************************
    // Values after reset.
    // ****************************************************************
    localparam logic [15:0] DIR_RST     = IMPL_MASK;
    localparam logic [15:0] LAT_RST     = 16'h0000;
    localparam logic [15:0] ODC_RST     = 16'h0000;
    localparam logic [15:0] ANCFG_RST   = 16'h0000;
    localparam logic [15:0] CNEN_RST    = 16'h0000;
    localparam logic [15:0] CNPU_RST    = 16'h0000;
    localparam logic [15:0] SYNC_RST    = 16'h0000;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    // Companion selected by address bits 3:2.
    typedef enum logic [1:0] {
        OP_BASE = 2'b00,
        OP_CLR  = 2'b01,
        OP_SET  = 2'b10,
        OP_INV  = 2'b11
    } cmp_op_t;

endpackage : gpio_port_pkg

// File: hw/pin_sync2.sv
// Two-stage synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int W = 16
) (
    // Clock, reset and freeze.
    input  wire logic         ref_clk_in,
    input  wire logic         srst_in,
    input  wire logic         ce_in,
    // Levels.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // ****************************************************************
    // Synchroniser stages.
    // ****************************************************************
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;

    // Only the second stage reads the first, to give metastability a
    // full cycle to settle.
    always_comb begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        if (srst_in) begin
            next_stage1 = '0;
            next_stage2 = '0;
        end else if (ce_in) begin
            next_stage1 = async_in;
            next_stage2 = stage1;
        end
    end

    // Register the stages.
    always_ff @(posedge ref_clk_in) begin
        stage1 <= next_stage1;
        stage2 <= next_stage2;
    end

    assign sync_out = stage2;

endmodule : pin_sync2

// File: hw/parallel_io_port.sv
// Parallel I/O port: direction, latch, pin read, companions, analog
// select, open drain, change notification and pull-ups.
// Assumes one clock, a synchronous reset and a Wishbone master.
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps

module parallel_io_port (
    // Clock, reset and freeze.
    input  wire logic                              ref_clk_in,
    input  wire logic                              srst_in,
    input  wire logic                              ce_in,
    // Wishbone slave.
    input  wire logic                              wb_cyc_in,
    input  wire logic                              wb_stb_in,
    input  wire logic                              wb_we_in,
    input  wire logic [gpio_port_pkg::ADR_W-1:0]   wb_adr_in,
    input  wire logic [gpio_port_pkg::SEL_W-1:0]   wb_sel_in,
    input  wire logic [gpio_port_pkg::DATA_W-1:0]  wb_dat_in,
    output logic      [gpio_port_pkg::DATA_W-1:0]  wb_dat_out,
    output logic                                   wb_ack_out,
    // Pins.
    input  wire logic [gpio_port_pkg::PORT_W-1:0]  pin_in,
    output logic      [gpio_port_pkg::PORT_W-1:0]  pin_out,
    output logic      [gpio_port_pkg::PORT_W-1:0]  pin_oe_out,
    output logic      [gpio_port_pkg::PORT_W-1:0]  pullup_en_out,
    output logic      [gpio_port_pkg::PORT_W-1:0]  analog_switch_out,
    // Comparator reference and change notification.
    input  wire logic                              cref_enable_in,
    output logic                                   change_irq_out
);
    import gpio_port_pkg::*;

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic [15:0] pin_direction;
    logic [15:0] output_latch;
    logic [15:0] open_drain_select;
    logic [15:0] analog_pin_config;
    logic [15:0] change_notify_enable;
    logic [15:0] change_pullup_enable;
    logic [15:0] next_pin_direction;
    logic [15:0] next_output_latch;
    logic [15:0] next_open_drain_select;
    logic [15:0] next_analog_pin_config;
    logic [15:0] next_change_notify_enable;
    logic [15:0] next_change_pullup_enable;
    logic        wb_ack;
    logic        next_wb_ack;
    logic [31:0] wb_dat;
    logic [31:0] next_wb_dat;
    logic [15:0] pin_sync;
    logic [15:0] sync_prev;
    logic [15:0] next_sync_prev;
    logic        change_irq;
    logic        next_change_irq;
    logic [15:0] digital_en;
    logic [15:0] port_view;
    logic [15:0] cref_mask;
    logic [15:0] change_hit;
    logic [15:0] byte_mask;
    logic [15:0] wr_data;
    logic [3:0]  reg_idx;
    cmp_op_t     reg_op;
    logic        bus_req;
    logic        wr_go;

    // Base write, clear, set or invert of the bits picked by mask.
    function automatic logic [15:0] apply_op(
        input logic [15:0] old_val,
        input logic [15:0] wd,
        input logic [15:0] bm,
        input cmp_op_t     op
    );
        logic [15:0] hit;
        hit = wd & bm;
        case (op)
            OP_BASE: apply_op = (old_val & ~bm) | hit;
            OP_CLR:  apply_op = old_val & ~hit;
            OP_SET:  apply_op = old_val | hit;
            OP_INV:  apply_op = old_val ^ hit;
            default: apply_op = old_val;
        endcase
    endfunction : apply_op

    // ****************************************************************
    // Pin input path.
    // ****************************************************************
    // Pins are asynchronous to the clock, so both read path and change
    // detection see only the synchronised copy.
    pin_sync2 #(.W(PORT_W)) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .async_in   (pin_in),
        .sync_out   (pin_sync)
    );

    // Analog pins lose their digital input; pins without an analog
    // function are always digital.
    assign digital_en = analog_pin_config | ~ANALOG_MASK;
    assign port_view  = pin_sync & digital_en & IMPL_MASK;
    assign cref_mask  = cref_enable_in ? CREF_MASK : 16'h0000;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    assign reg_idx   = wb_adr_in[7:4];
    assign reg_op    = cmp_op_t'(wb_adr_in[3:2]);
    assign bus_req   = wb_cyc_in & wb_stb_in;
    // The write lands on the edge that also shows ack to the master.
    assign wr_go     = ce_in & bus_req & wb_we_in & wb_ack;
    assign byte_mask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    assign wr_data   = wb_dat_in[15:0];

    // ****************************************************************
    // Register file next values.
    // ****************************************************************
    always_comb begin
        next_pin_direction        = pin_direction;
        next_output_latch         = output_latch;
        next_open_drain_select    = open_drain_select;
        next_analog_pin_config    = analog_pin_config;
        next_change_notify_enable = change_notify_enable;
        next_change_pullup_enable = change_pullup_enable;
        if (srst_in) begin
            next_pin_direction        = DIR_RST;
            next_output_latch         = LAT_RST;
            next_open_drain_select    = ODC_RST;
            next_analog_pin_config    = ANCFG_RST;
            next_change_notify_enable = CNEN_RST;
            next_change_pullup_enable = CNPU_RST;
        end else if (wr_go) begin
            // Every base register has the three companions.
            case (reg_idx)
                IDX_DIR:   next_pin_direction = IMPL_MASK & apply_op(
                    pin_direction, wr_data, byte_mask, reg_op);
                // A port write and a latch write share one latch.
                IDX_PORT, IDX_LAT: next_output_latch = IMPL_MASK & apply_op(
                    output_latch, wr_data, byte_mask, reg_op);
                IDX_ODC:   next_open_drain_select = IMPL_MASK & apply_op(
                    open_drain_select, wr_data, byte_mask, reg_op);
                IDX_ANCFG: next_analog_pin_config = ANALOG_MASK & IMPL_MASK
                    & apply_op(analog_pin_config, wr_data, byte_mask, reg_op);
                IDX_CNEN:  next_change_notify_enable = IMPL_MASK & apply_op(
                    change_notify_enable, wr_data, byte_mask, reg_op);
                IDX_CNPU:  next_change_pullup_enable = IMPL_MASK & apply_op(
                    change_pullup_enable, wr_data, byte_mask, reg_op);
                default:   next_pin_direction = pin_direction;
            endcase
        end
    end

    // Register the register file; a low clock enable freezes it.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || ce_in) begin
            pin_direction        <= next_pin_direction;
            output_latch         <= next_output_latch;
            open_drain_select    <= next_open_drain_select;
            analog_pin_config    <= next_analog_pin_config;
            change_notify_enable <= next_change_notify_enable;
            change_pullup_enable <= next_change_pullup_enable;
        end
    end

    // ****************************************************************
    // Bus answer.
    // ****************************************************************
    // Ack one cycle after the request, dropped the cycle after. Reads
    // of companions and unmapped offsets answer zero.
    always_comb begin
        next_wb_ack = 1'b0;
        next_wb_dat = wb_dat;
        if (srst_in) begin
            next_wb_dat = RDATA_RST;
        end else if (bus_req && !wb_ack) begin
            next_wb_ack = 1'b1;
            next_wb_dat = RDATA_RST;
            if (!wb_we_in && reg_op == OP_BASE) begin
                case (reg_idx)
                    IDX_DIR:   next_wb_dat[15:0] = pin_direction;
                    IDX_PORT:  next_wb_dat[15:0] = port_view;
                    IDX_LAT:   next_wb_dat[15:0] = output_latch;
                    IDX_ODC:   next_wb_dat[15:0] = open_drain_select;
                    IDX_ANCFG: next_wb_dat[15:0] = analog_pin_config;
                    IDX_CNEN:  next_wb_dat[15:0] = change_notify_enable;
                    IDX_CNPU:  next_wb_dat[15:0] = change_pullup_enable;
                    default:   next_wb_dat[15:0] = 16'h0000;
                endcase
            end
        end
    end

    // Register the bus answer.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || ce_in) begin
            wb_ack <= next_wb_ack;
            wb_dat <= next_wb_dat;
        end
    end

    assign wb_ack_out = wb_ack;
    assign wb_dat_out = wb_dat;

    // ****************************************************************
    // Change notification.
    // ****************************************************************
    // A pin in analog mode has no digital input and cannot notify.
    assign change_hit = (pin_sync ^ sync_prev) & change_notify_enable &
                        digital_en;

    always_comb begin
        next_sync_prev  = pin_sync;
        next_change_irq = |change_hit;
        if (srst_in) begin
            next_sync_prev  = SYNC_RST;
            next_change_irq = 1'b0;
        end
    end

    // Register previous sample and request pulse.
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || ce_in) begin
            sync_prev  <= next_sync_prev;
            change_irq <= next_change_irq;
        end
    end

    assign change_irq_out = change_irq;

    // ****************************************************************
    // Pin drivers.
    // ****************************************************************
    // Open drain: a latch one releases the pin instead of driving it.
    assign pin_out           = output_latch & ~open_drain_select;
    assign pin_oe_out        = ~pin_direction & IMPL_MASK &
                               ~(open_drain_select & output_latch) &
                               ~cref_mask;
    assign pullup_en_out     = change_pullup_enable;
    assign analog_switch_out = (~digital_en & IMPL_MASK) | cref_mask;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    property p_dir_drive;
        (pin_oe_out & pin_direction) == 16'h0000;
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("pin driven while its direction is input");
    property p_reset_dir;
        disable iff (1'b0)
        $past(srst_in) |-> pin_direction == IMPL_MASK &&
                           pin_oe_out == 16'h0000;
    endproperty
    a_reset_dir: assert property (p_reset_dir)
        else $error("pins not all inputs after reset");
    property p_reset_ancfg;
        disable iff (1'b0)
        $past(srst_in) |-> analog_pin_config == 16'h0000;
    endproperty
    a_reset_ancfg: assert property (p_reset_ancfg)
        else $error("analog config not zero after reset");
    property p_port_read;
        ce_in && bus_req && !wb_we_in && !wb_ack && reg_idx == IDX_PORT &&
        reg_op == OP_BASE |=> wb_ack_out &&
                              wb_dat_out[15:0] == $past(port_view);
    endproperty
    a_port_read: assert property (p_port_read)
        else $error("port read does not return sampled pins");
    property p_analog_zero;
        ce_in && bus_req && !wb_we_in && !wb_ack && reg_idx == IDX_PORT
        |=> (wb_dat_out[15:0] & ~$past(digital_en)) == 16'h0000;
    endproperty
    a_analog_zero: assert property (p_analog_zero)
        else $error("analog pin reads non-zero in port register");
    property p_port_write;
        wr_go && reg_idx == IDX_PORT && reg_op == OP_BASE &&
        wb_sel_in[1:0] == 2'b11
        |=> output_latch == ($past(wr_data) & IMPL_MASK);
    endproperty
    a_port_write: assert property (p_port_write)
        else $error("port write did not load the latch");
    property p_latch_inv;
        wr_go && reg_idx == IDX_LAT && reg_op == OP_INV &&
        wb_sel_in[1:0] == 2'b11
        |=> output_latch == ($past(output_latch) ^
                             ($past(wr_data) & IMPL_MASK));
    endproperty
    a_latch_inv: assert property (p_latch_inv)
        else $error("invert companion changed wrong bits");
    property p_unimpl_zero;
        ((pin_direction | output_latch) & ~IMPL_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented pin bit is set");
    property p_open_drain;
        (pin_out & open_drain_select) == 16'h0000;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin driven high");
    property p_cref;
        cref_enable_in |-> (pin_oe_out & CREF_MASK) == 16'h0000 &&
                           (analog_switch_out & CREF_MASK) == CREF_MASK;
    endproperty
    a_cref: assert property (p_cref)
        else $error("reference pin still under digital control");
    property p_change;
        ce_in && (change_hit != 16'h0000) |=> change_irq_out;
    endproperty
    a_change: assert property (p_change)
        else $error("pin change gave no interrupt request");

endmodule : parallel_io_port

// File: verification/board_pins_model.sv
// Board model for the port pins: resolves each wire from device
// drive, board drive and weak pull-ups. Assumes one clock.
`timescale 1ns/1ps
module board_pins_model (
    // Clock.
    input  wire logic        ref_clk_in,
    // Device side.
    input  wire logic [15:0] dev_out_in,
    input  wire logic [15:0] dev_oe_in,
    input  wire logic [15:0] pullup_in,
    // Board side.
    input  wire logic [15:0] ext_val_in,
    input  wire logic [15:0] ext_drv_in,
    output logic      [15:0] level_out
);
    logic [15:0] last = 16'h0000;

    // Remember each level so that a floating wire can show its inverse.
    always_ff @(posedge ref_clk_in) begin
        last <= level_out;
    end

    // Device drive wins, then the board, then the pull-up. A floating
    // wire toggles, so no check leans on the simulator's choice.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (dev_oe_in[i]) begin
                level_out[i] = dev_out_in[i];
            end else if (ext_drv_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = ~last[i];
            end
        end
    end
endmodule : board_pins_model

// File: verification/tb_parallel_io_port.sv
// Self-checking bench for the parallel I/O port over Wishbone.
// Assumes the board model file is compiled before this one.
`timescale 1ns/1ps
module tb_parallel_io_port;
    import gpio_port_pkg::*;
    logic        ref_clk_in, srst_in, cyc, stb, we, ack, irq, cref_en;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    logic [15:0] pins, dout, doe, pu, asw, ext_val, ext_drv;
    int          n_fail, n_compared, cnt;
    // Companion writes and the base value expected after each.
    logic [7:0]  t_adr [6] = '{8'h24, 8'h28, 8'h2C, 8'h1C, 8'h08, 8'h04};
    logic [15:0] t_dat [6] = '{16'h0030, 16'h8001, 16'hFFFF, 16'h0001,
                               16'hFFFF, 16'h0100};
    logic [15:0] t_exp [6] = '{16'h1248, 16'h9249, 16'h2DB6, 16'h2DB7,
                               16'hBFFF, 16'hBEFF};
    // Base register read back after each companion write.
    logic [7:0]  t_rd  [6] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h00, 8'h00};
    int          c_pin [3] = '{8, 9, 0};
    logic [31:0] c_n   [3] = '{32'h1, 32'h0, 32'h0};

    parallel_io_port parallel_io_port_inst (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(1'b1),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .pin_in(pins), .pin_out(dout), .pin_oe_out(doe),
        .pullup_en_out(pu), .analog_switch_out(asw),
        .cref_enable_in(cref_en), .change_irq_out(irq));

    board_pins_model board_pins_model_inst (
        .ref_clk_in(ref_clk_in), .dev_out_in(dout), .dev_oe_in(doe),
        .pullup_in(pu), .ext_val_in(ext_val), .ext_drv_in(ext_drv),
        .level_out(pins));

    // ****************************************************************
    // Clock and shared tasks.
    // ****************************************************************
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge ref_clk_in);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do begin
            @(posedge ref_clk_in);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            wrap_up();
        end
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(rd, exp);
    endtask : rchk

    // Counts change pulses over a window of n edges.
    task automatic pulses(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge ref_clk_in);
            if (irq === 1'b1) cnt++;
        end
    endtask : pulses

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        n_fail = 0;
        n_compared = 0;
        {srst_in, cyc, stb, we, adr, sel, wdat, cref_en} = '0;
        srst_in = 1'b1;
        ext_val = 16'hA5C3;
        ext_drv = 16'hFFFF;
        repeat (5) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        chk({16'h0000, doe}, 32'h0000_0000);
        rchk(8'h00, 32'h0000_BFFF);
        rchk(8'h40, 32'h0000_0000);
        chk({31'h0, asw[0]}, 32'h0000_0001);
        $display("test reset finished");
        bus(1'b1, 8'h10, 32'h0000_1234, 4'hF);
        rchk(8'h20, 32'h0000_1234);
        // Only the low byte lane is enabled here.
        bus(1'b1, 8'h20, 32'h0000_5678, 4'h1);
        rchk(8'h20, 32'h0000_1278);
        bus(1'b1, 8'h00, 32'h0000_0000, 4'hF);
        rchk(8'h00, 32'h0000_0000);
        chk({doe, dout}, 32'hBFFF_1278);
        rchk(8'h10, 32'h0000_1200);
        foreach (t_adr[i]) begin
            bus(1'b1, t_adr[i], {16'h0000, t_dat[i]}, 4'hF);
            rchk(t_rd[i], {16'h0000, t_exp[i]});
        end
        $display("test latch finished");
        bus(1'b1, 8'h08, 32'h0000_FFFF, 4'hF);
        rchk(8'h10, 32'h0000_A500);
        bus(1'b1, 8'h48, 32'h0000_00FF, 4'hF);
        rchk(8'h10, 32'h0000_A5C3);
        chk({31'h0, asw[0]}, 32'h0000_0000);
        bus(1'b1, 8'h68, 32'h0000_0008, 4'hF);
        @(posedge ref_clk_in);
        chk({16'h0000, pu}, 32'h0000_0008);
        ext_drv <= 16'hFFF7;
        repeat (3) @(posedge ref_clk_in);
        rchk(8'h10, 32'h0000_A5CB);
        $display("test input finished");
        bus(1'b1, 8'h04, 32'h0000_FFFF, 4'hF);
        bus(1'b1, 8'h20, 32'h0000_00F0, 4'hF);
        bus(1'b1, 8'h30, 32'h0000_0030, 4'hF);
        @(posedge ref_clk_in);
        chk({doe, dout}, 32'hBFCF_00C0);
        cref_en <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        chk({doe, 15'h0, asw[10]}, 32'hBBCF_0001);
        cref_en <= 1'b0;
        $display("test output finished");
        bus(1'b1, 8'h08, 32'h0000_FFFF, 4'hF);
        bus(1'b1, 8'h44, 32'h0000_0001, 4'hF);
        bus(1'b1, 8'h50, 32'h0000_0301, 4'hF);
        bus(1'b1, 8'h54, 32'h0000_0200, 4'hF);
        foreach (c_pin[i]) begin
            @(posedge ref_clk_in);
            ext_val[c_pin[i]] <= ~ext_val[c_pin[i]];
            pulses(2);
            chk(cnt, 32'h0000_0000);
            pulses(6);
            chk(cnt, c_n[i]);
        end
        $display("test change finished");
        bus(1'b1, 8'h70, 32'h0000_FFFF, 4'hF);
        rchk(8'h70, 32'h0000_0000);
        bus(1'b1, 8'h04, 32'h0000_FFFF, 4'hF);
        @(posedge ref_clk_in);
        srst_in <= 1'b1;
        @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rchk(8'h00, 32'h0000_BFFF);
        rchk(8'h20, 32'h0000_0000);
        rchk(8'h40, 32'h0000_0000);
        $display("test rereset finished");
        wrap_up();
    end
endmodule : tb_parallel_io_port
